// >>> logic/tlp_regs.vh
`ifndef TLP_REGS_VH
`define TLP_REGS_VH

// two-wire target address (7-bit) and byte pointer space
`define TLP_DEV_ADDR    7'h50
`define TLP_PTR_RST     8'h00

// lower page byte offsets
`define TLP_A_ID        8'h00
`define TLP_A_STAT      8'h02
`define TLP_A_LOS       8'h03
`define TLP_A_TXF       8'h04
`define TLP_A_TEMP      8'h06
`define TLP_A_VCC       8'h07
`define TLP_A_RX12      8'h09
`define TLP_A_RX34      8'h0A
`define TLP_A_BIAS      8'h0B
`define TLP_A_CTRL_LO   8'h56
`define TLP_A_CTRL_HI   8'h61
`define TLP_A_MASK_LO   8'h64
`define TLP_A_MASK_HI   8'h6A
`define TLP_A_PAGE      8'h7F

// module_status bit positions
`define TLP_ST_PAGED    2
`define TLP_ST_INT      1
`define TLP_ST_DNR      0

// flag vector layout, one slot per latched flag bit
`define TLP_NFLAG       40
`define TLP_SEL_LOS     40'h000000000F
`define TLP_SEL_TXF     40'h00000000F0
`define TLP_SEL_TEMP    40'h0000000F00
`define TLP_SEL_VCC     40'h000000F000
`define TLP_SEL_RX12    40'h0000FF0000
`define TLP_SEL_RX34    40'h00FF000000
`define TLP_SEL_BIAS    40'hFF00000000
`define TLP_SEL_NONE    40'h0000000000

// reset values and writable byte counts
`define TLP_CTRL_RST    8'h00
`define TLP_MASK_RST    8'h00
`define TLP_PAGE_RST    8'h00
`define TLP_NCTRL       12
`define TLP_NMASK       7

// byte framing
`define TLP_BITS_BYTE   4'h8
`define TLP_BIT_ZERO    4'h0
`define TLP_BIT_ONE     4'h1

// timing: monitor data ready limit
`define TLP_T_DATA_MS   2000
`define TLP_CLK_KHZ     125000

`endif

// >>> logic/tlp_sync.v
`timescale 1ns/1ns
// two-stage synchroniser for levels arriving from outside core_clk
module tlp_sync #(
  parameter W = 2
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         nrst,
  // asynchronous in, synchronised out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= {W{1'b1}};
      q      <= {W{1'b1}};
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// >>> logic/tlp_flags.v
`timescale 1ns/1ns
// latched flag bank: sticky set on condition, cleared by a read
module tlp_flags #(
  parameter W = 40
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         nrst,
  // live conditions, read clear strobes, interrupt masks
  input  wire [W-1:0] cond,
  input  wire [W-1:0] clr,
  input  wire [W-1:0] mask,
  // latched flags and unmasked summary
  output reg  [W-1:0] flags_q,
  output wire         irq
);

  // a condition present in the clearing cycle keeps its flag set
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= {W{1'b0}};
    else
      flags_q <= (flags_q & ~clr) | cond;
  end

  // masking acts in the same cycle, far inside the limit
  assign irq = |(flags_q & ~mask);

endmodule

// >>> logic/tlp_top.v
`timescale 1ns/1ns
// Overview of operation
// - read-only id, status, flag, monitor, reserved regions
// - writable control, mask, reserved, page-select bytes; here reserved bytes ignore writes and read zero
// - status byte 2 bit 2 reads one
// - status bit 1 mirrors interrupt pin
// - data-not-ready high until monitors valid, then low
// - flags zero normally, set on condition
// - byte 3 holds channel receive loss flags
// - byte 4 holds channel transmit fault flags
// - byte 6 holds temperature alarms and warnings
// - byte 7 holds supply alarms and warnings
// - bytes 9, 10 hold receive power flags
// - byte 11 holds transmit bias flags
// - read clears flag; interrupt releases quickly
// - data ready and interrupt within 2000 ms
// - lower page addressable; page byte selects upper; here upper-page bytes read zero for every page byte
// - mask bit inhibits interrupt within 100 ms
`include "tlp_regs.vh"
module tlp_top #(
  parameter [6:0]  DEV_ADDR = `TLP_DEV_ADDR,
  parameter [7:0]  ID_CODE  = 8'h5A, // arbitrary value
  parameter [27:0] RDY_CYC  = `TLP_T_DATA_MS * `TLP_CLK_KHZ
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         nrst,
  // two-wire serial bus, open drain data
  input  wire         scl_in,
  input  wire         sda_in,
  output wire         sda_out,
  output reg          sda_oe,
  // interrupt pin, active low
  output reg          interrupt_request_n,
  // live conditions from the monitor logic on core_clk
  input  wire [3:0]   rx_los_cond,
  input  wire [3:0]   tx_fault_cond,
  input  wire [3:0]   temp_cond,
  input  wire [3:0]   vcc_cond,
  input  wire [15:0]  rx_power_cond,
  input  wire [7:0]   tx_bias_cond,
  input  wire         mon_valid,
  // stored writable bytes
  output wire [95:0]  ctrl_bytes,
  output wire [7:0]   page_select
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ADDR  = 6'h02;
  localparam [5:0] S_PTR   = 6'h04;
  localparam [5:0] S_WDATA = 6'h08;
  localparam [5:0] S_RDATA = 6'h10;
  localparam [5:0] S_RACK  = 6'h20;

  reg  [5:0]  st_q;
  reg  [3:0]  bitcnt_q;
  reg  [7:0]  sh_q;
  reg  [7:0]  ptr_q;
  reg         ack_q;
  reg         rw_q;
  reg         scl_d1_q;
  reg         sda_d1_q;
  reg  [7:0]  ctrl_q [0:`TLP_NCTRL-1];
  reg  [7:0]  mask_q [0:`TLP_NMASK-1];
  reg  [7:0]  page_q;
  reg         dnr_q;
  reg         rdy_evt_q;
  reg  [27:0] rdy_cnt_q;
  reg  [7:0]  rd_byte;
  reg         load;
  reg         wr;
  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start;
  wire        stop;
  wire [7:0]  ctrl_idx;
  wire [7:0]  mask_idx;
  wire        in_ctrl;
  wire        in_mask;
  wire [39:0] flags;
  wire [39:0] cond;
  wire [39:0] mask_vec;
  wire [39:0] clr_vec;
  wire        flag_irq;
  wire        rdy_done;
  integer     i;

  // flag bits touched by reading a given byte
  function [39:0] flag_sel;
    input [7:0] a;
    begin
      case (a)
        `TLP_A_LOS:  flag_sel = `TLP_SEL_LOS;
        `TLP_A_TXF:  flag_sel = `TLP_SEL_TXF;
        `TLP_A_TEMP: flag_sel = `TLP_SEL_TEMP;
        `TLP_A_VCC:  flag_sel = `TLP_SEL_VCC;
        `TLP_A_RX12: flag_sel = `TLP_SEL_RX12;
        `TLP_A_RX34: flag_sel = `TLP_SEL_RX34;
        `TLP_A_BIAS: flag_sel = `TLP_SEL_BIAS;
        default:     flag_sel = `TLP_SEL_NONE;
      endcase
    end
  endfunction

  tlp_sync #(
    .W (2)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        ({scl_in, sda_in}),
    .q        ({scl_s, sda_s})
  );

  assign scl_rise = scl_s & ~scl_d1_q;
  assign scl_fall = ~scl_s & scl_d1_q;
  assign start    = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  assign stop     = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // flag vector in byte order, nibbles high to low within each byte
  assign cond = {tx_bias_cond, rx_power_cond[15:8], rx_power_cond[7:0],
                 vcc_cond, temp_cond, tx_fault_cond, rx_los_cond};
  assign mask_vec = {mask_q[6], mask_q[5], mask_q[4], mask_q[3][7:4],
                     mask_q[2][7:4], mask_q[1][3:0], mask_q[0][3:0]};
  assign clr_vec  = load ? flag_sel(ptr_q) : `TLP_SEL_NONE;

  tlp_flags #(
    .W (`TLP_NFLAG)
  ) u_flags (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cond     (cond),
    .clr      (clr_vec),
    .mask     (mask_vec),
    .flags_q  (flags),
    .irq      (flag_irq)
  );

  assign ctrl_idx = ptr_q - `TLP_A_CTRL_LO;
  assign mask_idx = ptr_q - `TLP_A_MASK_LO;
  assign in_ctrl  = (ptr_q >= `TLP_A_CTRL_LO) && (ptr_q <= `TLP_A_CTRL_HI);
  assign in_mask  = (ptr_q >= `TLP_A_MASK_LO) && (ptr_q <= `TLP_A_MASK_HI);

  // read map; monitor, reserved and upper-page bytes read zero
  always @*
  begin
    case (ptr_q)
      `TLP_A_ID:   rd_byte = ID_CODE;
      `TLP_A_STAT: rd_byte = {5'h00, 1'b1, interrupt_request_n,
                              dnr_q};
      `TLP_A_LOS:  rd_byte = {4'h0, flags[3:0]};
      `TLP_A_TXF:  rd_byte = {4'h0, flags[7:4]};
      `TLP_A_TEMP: rd_byte = {flags[11:8], 4'h0};
      `TLP_A_VCC:  rd_byte = {flags[15:12], 4'h0};
      `TLP_A_RX12: rd_byte = flags[23:16];
      `TLP_A_RX34: rd_byte = flags[31:24];
      `TLP_A_BIAS: rd_byte = flags[39:32];
      `TLP_A_PAGE: rd_byte = page_q;
      default:
      begin
        if (in_ctrl)
          rd_byte = ctrl_q[ctrl_idx[3:0]];
        else if (in_mask)
          rd_byte = mask_q[mask_idx[2:0]];
        else
          rd_byte = 8'h00;
      end
    endcase
  end

  // byte load for transmit and byte store on write, both at an ack edge
  always @*
  begin
    load = 1'b0;
    wr   = 1'b0;
    if (scl_fall && !start && !stop)
    begin
      if (st_q == S_ADDR && ack_q && rw_q)
        load = 1'b1;
      if (st_q == S_RACK && ack_q)
        load = 1'b1;
      if (st_q == S_WDATA && !ack_q && bitcnt_q == `TLP_BITS_BYTE)
        wr = 1'b1;
    end
  end

  // two-wire target: sample on scl rise, change data on scl fall
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q     <= S_IDLE;
      bitcnt_q <= `TLP_BIT_ZERO;
      sh_q     <= 8'h00;
      ptr_q    <= `TLP_PTR_RST;
      ack_q    <= 1'b0;
      rw_q     <= 1'b0;
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end
    else
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      if (start)
      begin
        st_q     <= S_ADDR;
        bitcnt_q <= `TLP_BIT_ZERO;
        ack_q    <= 1'b0;
      end
      else if (stop)
      begin
        st_q  <= S_IDLE;
        ack_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          S_ADDR, S_PTR, S_WDATA:
          begin
            if (scl_rise && bitcnt_q != `TLP_BITS_BYTE)
            begin
              sh_q     <= {sh_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + `TLP_BIT_ONE;
            end
            else if (scl_fall && ack_q)
            begin
              ack_q    <= 1'b0;
              bitcnt_q <= `TLP_BIT_ZERO;
              if (st_q == S_ADDR && rw_q)
              begin
                st_q  <= S_RDATA;
                sh_q  <= rd_byte;
                ptr_q <= ptr_q + 8'h01;
              end
              else if (st_q == S_ADDR)
                st_q <= S_PTR;
              else
                st_q <= S_WDATA;
            end
            else if (scl_fall && bitcnt_q == `TLP_BITS_BYTE)
            begin
              if (st_q == S_ADDR)
              begin
                if (sh_q[7:1] == DEV_ADDR)
                begin
                  ack_q <= 1'b1;
                  rw_q  <= sh_q[0];
                end
                else
                  st_q <= S_IDLE;
              end
              else
              begin
                ack_q <= 1'b1;
                if (st_q == S_PTR)
                  ptr_q <= sh_q;
                else
                  ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          S_RDATA:
          begin
            if (scl_rise)
              bitcnt_q <= bitcnt_q + `TLP_BIT_ONE;
            else if (scl_fall && bitcnt_q == `TLP_BITS_BYTE)
              st_q <= S_RACK;
            else if (scl_fall)
              sh_q <= {sh_q[6:0], 1'b1};
          end
          S_RACK:
          begin
            if (scl_rise)
            begin
              if (sda_s)
                st_q <= S_IDLE;
              else
                ack_q <= 1'b1;
            end
            else if (load)
            begin
              ack_q    <= 1'b0;
              st_q     <= S_RDATA;
              bitcnt_q <= `TLP_BIT_ZERO;
              sh_q     <= rd_byte;
              ptr_q    <= ptr_q + 8'h01;
            end
          end
          S_IDLE:
            ack_q <= 1'b0;
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

  // registered open-drain enable: ack, or a zero data bit being sent
  assign sda_out = 1'b0;
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      sda_oe <= 1'b0;
    else
      sda_oe <= (ack_q && st_q != S_RACK) ||
                (st_q == S_RDATA && !sh_q[7]);
  end

  // writable bytes; reserved writable bytes and read-only bytes ignore it
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < `TLP_NCTRL; i = i + 1)
        ctrl_q[i] <= `TLP_CTRL_RST;
      for (i = 0; i < `TLP_NMASK; i = i + 1)
        mask_q[i] <= `TLP_MASK_RST;
      page_q <= `TLP_PAGE_RST;
    end
    else if (wr)
    begin
      if (in_ctrl)
        ctrl_q[ctrl_idx[3:0]] <= sh_q;
      if (in_mask)
        mask_q[mask_idx[2:0]] <= sh_q;
      if (ptr_q == `TLP_A_PAGE)
        page_q <= sh_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TLP_NCTRL; g = g + 1)
    begin : g_ctrl
      assign ctrl_bytes[g*8 +: 8] = ctrl_q[g];
    end
  endgenerate
  assign page_select = page_q;

  // data-not-ready: cleared by valid monitors or by the time limit;
  // the limit guards against a monitor that never reports
  assign rdy_done = mon_valid || (rdy_cnt_q == RDY_CYC);

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dnr_q     <= 1'b1;
      rdy_evt_q <= 1'b0;
      rdy_cnt_q <= 28'h0000000;
    end
    else
    begin
      if (dnr_q && !rdy_done)
        rdy_cnt_q <= rdy_cnt_q + 28'h0000001;
      if (dnr_q && rdy_done)
        dnr_q <= 1'b0;
      // set wins over the clear by a status read
      if (dnr_q && rdy_done)
        rdy_evt_q <= 1'b1;
      else if (load && ptr_q == `TLP_A_STAT)
        rdy_evt_q <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      interrupt_request_n <= 1'b1;
    else
      interrupt_request_n <= ~(flag_irq | rdy_evt_q);
  end

endmodule

// >>> sim/tlp_top_chk_sva.sv
`timescale 1ns/1ns
module tlp_top_chk #(
  parameter int RDY_CYC = 200
) (
  // clock and reset
  input logic        core_clk,
  input logic        nrst,
  // two-wire bus and interrupt pin
  input logic        scl_in,
  input logic        sda_in,
  input logic        sda_out,
  input logic        sda_oe,
  input logic        interrupt_request_n,
  // live conditions
  input logic [3:0]  rx_los_cond,
  input logic [3:0]  tx_fault_cond,
  input logic [3:0]  temp_cond,
  input logic [3:0]  vcc_cond,
  input logic [15:0] rx_power_cond,
  input logic [7:0]  tx_bias_cond,
  input logic        mon_valid,
  // stored bytes
  input logic [95:0] ctrl_bytes,
  input logic [7:0]  page_select
);
  logic [15:0] cnt_q;
  logic [3:0]  hi_q;
  logic        seen_q;
  logic        mv_q;
  wire  [39:0] cv = {tx_bias_cond, rx_power_cond, vcc_cond, temp_cond,
                     tx_fault_cond, rx_los_cond};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= 16'h0000;
      hi_q   <= 4'h0;
      seen_q <= 1'b0;
      mv_q   <= 1'b0;
    end
    else
    begin
      if (cnt_q != 16'hFFFF)
        cnt_q <= cnt_q + 16'h0001;
      hi_q   <= !scl_in ? 4'h0 : (hi_q == 4'hF ? hi_q : hi_q + 4'h1);
      seen_q <= seen_q | (|cv) | mon_valid;
      mv_q   <= mv_q | mon_valid;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda_out not held low");
  reset_state_a: assert property ($rose(nrst) |->
    interrupt_request_n && !sda_oe) else $error("bad state after reset");
  quiet_start_a: assert property (cnt_q < 16'h0096 && !seen_q |->
    interrupt_request_n) else $error("interrupt with no cause");
  // temperature is left out: the bench masks it on purpose
  cond_irq_a: assert property (|{rx_los_cond, tx_fault_cond, vcc_cond,
    rx_power_cond, tx_bias_cond} |-> ##[1:3] !interrupt_request_n)
    else $error("condition did not raise interrupt");
  ready_timeout_a: assert property (cnt_q == RDY_CYC + 8 && !mv_q |->
    !interrupt_request_n) else $error("no interrupt after ready time");
  ready_event_a: assert property ($rose(mon_valid) &&
    cnt_q < RDY_CYC - 10 |-> ##[1:4] !interrupt_request_n)
    else $error("no interrupt on monitor ready");
  store_ack_a: assert property ($changed(page_select) ||
    $changed(ctrl_bytes) |-> ##[0:3] sda_oe)
    else $error("byte stored without acknowledge");
  scl_idle_a: assert property (hi_q > 4'hA |-> !sda_oe)
    else $error("data pulled low on idle bus");

  cover property ($fell(interrupt_request_n));
  cover property ($rose(sda_oe));
  cover property ($changed(page_select));
endmodule

bind tlp_top tlp_top_chk #(.RDY_CYC(RDY_CYC)) chk_i (
  .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe),
  .interrupt_request_n(interrupt_request_n),
  .rx_los_cond(rx_los_cond), .tx_fault_cond(tx_fault_cond),
  .temp_cond(temp_cond), .vcc_cond(vcc_cond),
  .rx_power_cond(rx_power_cond), .tx_bias_cond(tx_bias_cond),
  .mon_valid(mon_valid), .ctrl_bytes(ctrl_bytes),
  .page_select(page_select));

// >>> sim/tlp_host.sv
`timescale 1ns/1ns
`include "tlp_regs.vh"
module tlp_host (
  // timing reference and wire level
  input  logic core_clk,
  input  logic sda_w,
  // driven lines; data is open drain, scl stands high between frames
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // 64 ns bit: data moves mid-low, sampled mid-high
  task automatic xbit(input logic b, output logic r);
    tick(2);
    sda_low = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda_w;
    tick(2);
    scl = 1'b0;
  endtask
  // wait for the target to drop its ack before raising scl, so a
  // repeated start is not seen as a stop followed by a start
  task automatic start;
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop;
    tick(2);
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic xbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask
  task automatic wr(input logic [7:0] a, d, output logic ok);
    logic k0, k1, k2;
    start;
    xbyte({`TLP_DEV_ADDR, 1'b0}, k0);
    xbyte(a, k1);
    xbyte(d, k2);
    stop;
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    logic r;
    start;
    xbyte({`TLP_DEV_ADDR, 1'b0}, k);
    xbyte(a, k);
    start;
    xbyte({`TLP_DEV_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--)
    begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(1'b1, r);
    stop;
  endtask
  task automatic probe(input logic [6:0] dev, output logic ack);
    start;
    xbyte({dev, 1'b0}, ack);
    stop;
  endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`include "tlp_regs.vh"
module tb_top;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        mon_valid = 1'b0;
  logic [39:0] cv = 40'h0000000000;
  logic [7:0]  rv;
  logic        ok;
  wire         scl, sda_w, host_low, sda_out, sda_oe, irq_n;
  wire  [95:0] ctrl;
  wire  [7:0]  page;
  int          n_errors = 0;
  int          total_checks = 0;
  logic [7:0]  fa [7] = '{`TLP_A_LOS, `TLP_A_TXF, `TLP_A_TEMP, `TLP_A_VCC,
                          `TLP_A_RX12, `TLP_A_RX34, `TLP_A_BIAS};
  logic [39:0] fc [7] = '{40'h000000000A, 40'h00000000A0, 40'h0000000A00,
                          40'h000000A000, 40'h0000A50000, 40'h005A000000,
                          40'hC300000000};
  logic [7:0]  fe [7] = '{8'h0A, 8'h0A, 8'hA0, 8'hA0, 8'hA5, 8'h5A, 8'hC3};
  logic [7:0]  ro [8] = '{8'h01, 8'h05, 8'h08, 8'h16, 8'h51, 8'h55, 8'h62,
                          8'h6B};
  logic [7:0]  wa [3] = '{8'h56, 8'h61, 8'h7F};
  logic [7:0]  wd [3] = '{8'h3C, 8'hC5, 8'h02};

  always #4 core_clk = ~core_clk;
  // pull-up on the data wire
  assign sda_w = !((sda_oe && !sda_out) || host_low);

  tlp_top #(.ID_CODE(8'hA7), .RDY_CYC(28'h00005DC)) tlp_top_i (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .interrupt_request_n(irq_n),
    .rx_los_cond(cv[3:0]), .tx_fault_cond(cv[7:4]), .temp_cond(cv[11:8]),
    .vcc_cond(cv[15:12]), .rx_power_cond(cv[31:16]),
    .tx_bias_cond(cv[39:32]), .mon_valid(mon_valid), .ctrl_bytes(ctrl),
    .page_select(page));
  tlp_host tlp_host_i (.core_clk(core_clk), .sda_w(sda_w), .scl(scl),
    .sda_low(host_low));

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, e);
    tlp_host_i.rd(a, rv);
    chk($sformatf("byte %0d", a), e, rv);
  endtask
  task automatic wr(input logic [7:0] a, d);
    tlp_host_i.wr(a, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    mon_valid = 1'b0;
    wait_n(20);
    nrst = 1'b1;
    wait_n(10);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    wait_n(40000);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    wrap_up;
  end

  initial
  begin
    do_reset;
    rchk(`TLP_A_STAT, 8'h07);
    wait_n(1300);
    chk("irq ready", 8'h00, {7'h00, irq_n});
    rchk(`TLP_A_STAT, 8'h04);
    rchk(`TLP_A_STAT, 8'h06);
    $display("test status done");
    wr(`TLP_A_ID, 8'hFF);
    rchk(`TLP_A_ID, 8'hA7);
    foreach (ro[i])
    begin
      wr(ro[i], 8'hFF);
      rchk(ro[i], 8'h00);
    end
    $display("test read-only done");
    foreach (wa[i])
    begin
      wr(wa[i], wd[i]);
      rchk(wa[i], wd[i]);
    end
    chk("ctrl 86", 8'h3C, ctrl[7:0]);
    chk("ctrl 97", 8'hC5, ctrl[95:88]);
    chk("page", 8'h02, page);
    $display("test writable done");
    foreach (fa[i])
    begin
      cv = fc[i];
      wait_n(2);
      cv = 40'h0000000000;
      wait_n(6);
      chk("irq flag", 8'h00, {7'h00, irq_n});
      rchk(fa[i], fe[i]);
      rchk(fa[i], 8'h00);
      chk("irq clear", 8'h01, {7'h00, irq_n});
    end
    $display("test flags done");
    wr(8'h66, 8'hF0);
    rchk(8'h66, 8'hF0);
    cv = 40'h0000000F00;
    wait_n(2);
    cv = 40'h0000000000;
    wait_n(20);
    chk("irq masked", 8'h01, {7'h00, irq_n});
    rchk(`TLP_A_TEMP, 8'hF0);
    wr(8'h66, 8'h00);
    tlp_host_i.probe(7'h51, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    $display("test mask done");
    do_reset;
    chk("ctrl reset", 8'h00, ctrl[7:0]);
    chk("page reset", 8'h00, page);
    rchk(`TLP_A_STAT, 8'h07);
    mon_valid = 1'b1;
    wait_n(8);
    chk("irq ready", 8'h00, {7'h00, irq_n});
    rchk(`TLP_A_STAT, 8'h04);
    $display("test monitor ready done");
    wrap_up;
  end
endmodule
